// ===== design/serial_adc_control_interface.sv
// Control, serial port and conversion sequencer of an 8-bit serial converter
// Notes on behaviour
// - Produce an 8-bit successive-approximation result from the selected channel.
// - Select among eleven external inputs or the internal self-test source.
// - Start conversion on the eighth shift-clock falling edge after select falls.
// - A conversion lasts 36 system clock periods from start to result.
// - Conversion uses the address held in the address store at start.
// - On select falling, the previous result MSB appears without shift edges.
// - Remaining seven bits shift out on the first seven falling edges.
// - Output held at the MSB for four system cycles after the synchronised select falls.
// - Address in and result out share one shift-clock sequence.
// - Sampling runs automatically or under host timing control.
// - Serial result output has an enable, o_dout_oe, high while the synchronised select is low.
`timescale 1ns/1ps
module serial_adc_control_interface (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_io_clk,
    input wire logic i_sel_n,
    input wire logic i_addr_in,
    input wire logic [adc_ctrl_pkg::AIN_BITS-1:0] i_ain,
    input wire logic i_host_sample,
    input wire logic i_hold_req,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_busy
);
    // ********************************
    // Shift clock domain
    // ********************************
    logic io_rst_n;
    logic [2:0] rise_cnt;
    logic [3:0] addr_shift;
    logic [3:0] fall_cnt;
    logic [3:0] next_fall_cnt;
    logic [3:0] fall_gray;
    logic [3:0] addr_hold;
    logic start_tgl;
    logic start_edge_hit;

    // Frame logic is cleared while select is high
    assign io_rst_n = i_rst_n & ~i_sel_n;
    assign next_fall_cnt = (fall_cnt == adc_ctrl_pkg::START_EDGE) ? fall_cnt : fall_cnt + 4'h1;
    assign start_edge_hit = (next_fall_cnt == adc_ctrl_pkg::START_EDGE)
        && (fall_cnt != adc_ctrl_pkg::START_EDGE);

    // Address bits taken on rising edges, extra bits dropped
    always_ff @(posedge i_io_clk or negedge io_rst_n) begin
        if (!io_rst_n) begin
            rise_cnt <= 3'h0;
            addr_shift <= adc_ctrl_pkg::ADDR_RESET;
        end else if (rise_cnt != adc_ctrl_pkg::ADDR_EDGES) begin
            rise_cnt <= rise_cnt + 3'h1;
            addr_shift <= {addr_shift[2:0], i_addr_in};
        end
    end

    // Falling edge count, gray coded for the crossing
    always_ff @(negedge i_io_clk or negedge io_rst_n) begin
        if (!io_rst_n) begin
            fall_cnt <= 4'h0;
            fall_gray <= 4'h0;
        end else begin
            fall_cnt <= next_fall_cnt;
            fall_gray <= next_fall_cnt ^ (next_fall_cnt >> 1);
        end
    end

    // Address store and start event survive the end of the frame
    always_ff @(negedge i_io_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_hold <= adc_ctrl_pkg::ADDR_RESET;
            start_tgl <= 1'b0;
        end else if (start_edge_hit) begin
            addr_hold <= addr_shift;
            start_tgl <= ~start_tgl;
        end
    end

    // ********************************
    // Pin synchronisers
    // ********************************
    logic sel_s1;
    logic sel_s2;
    logic sel_d;
    logic [3:0] gray_s1;
    logic [3:0] gray_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_d;
    logic [adc_ctrl_pkg::AIN_BITS-1:0] ain_s1;
    logic [adc_ctrl_pkg::AIN_BITS-1:0] ain_s2;
    logic host_s1;
    logic host_s2;
    logic hold_s1;
    logic hold_s2;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            sel_d <= 1'b1;
            gray_s1 <= 4'h0;
            gray_s2 <= 4'h0;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_d <= 1'b0;
        end else begin
            sel_s1 <= i_sel_n;
            sel_s2 <= sel_s1;
            sel_d <= sel_s2;
            gray_s1 <= fall_gray;
            gray_s2 <= gray_s1;
            tgl_s1 <= start_tgl;
            tgl_s2 <= tgl_s1;
            tgl_d <= tgl_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ain_s1 <= '0;
            ain_s2 <= '0;
            host_s1 <= 1'b0;
            host_s2 <= 1'b0;
            hold_s1 <= 1'b0;
            hold_s2 <= 1'b0;
        end else begin
            ain_s1 <= i_ain;
            ain_s2 <= ain_s1;
            host_s1 <= i_host_sample;
            host_s2 <= host_s1;
            hold_s1 <= i_hold_req;
            hold_s2 <= hold_s1;
        end
    end

    // ********************************
    // Select noise filter
    // ********************************
    logic [1:0] filter_cnt;
    logic sel_fall;
    logic frame_live;

    assign sel_fall = sel_d & ~sel_s2;
    assign frame_live = ~sel_s2 & ~sel_fall & (filter_cnt == 2'h0);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filter_cnt <= 2'h0;
        end else if (sel_fall) begin
            filter_cnt <= adc_ctrl_pkg::FILTER_LOAD;
        end else if (filter_cnt != 2'h0) begin
            filter_cnt <= filter_cnt - 2'h1;
        end
    end

    // ********************************
    // Channel selection
    // ********************************
    logic [7:0] chan_level [adc_ctrl_pkg::NUM_SRC];
    logic [3:0] conv_addr;
    logic [7:0] sel_level;
    logic addr_external;

    genvar ch;
    generate
        for (ch = 0; ch < adc_ctrl_pkg::NUM_EXT; ch++) begin : g_chan
            assign chan_level[ch] = ain_s2[ch*adc_ctrl_pkg::RES_BITS +: adc_ctrl_pkg::RES_BITS];
        end
    endgenerate
    assign chan_level[adc_ctrl_pkg::NUM_EXT] = adc_ctrl_pkg::SELFTEST_CODE;

    // Addresses from self-test upward pick the self-test source
    assign addr_external = conv_addr < adc_ctrl_pkg::SELFTEST_ADDR;
    assign sel_level = addr_external ? chan_level[conv_addr] :
        chan_level[adc_ctrl_pkg::NUM_EXT];

    // ********************************
    // Conversion sequencer
    // ********************************
    adc_ctrl_pkg::conv_state_type state;
    adc_ctrl_pkg::conv_state_type next_state;
    logic [5:0] conv_cnt;
    logic [1:0] slot_cnt;
    logic [2:0] bit_idx;
    logic [7:0] sample;
    logic [7:0] work;
    logic [7:0] result;
    logic [7:0] trial;
    logic start_pulse;
    logic settle_end;
    logic bit_decide;
    logic conv_end;
    logic auto_take;
    logic host_track;

    assign start_pulse = tgl_s2 ^ tgl_d;
    assign settle_end = (state == adc_ctrl_pkg::ST_SETTLE) && (conv_cnt == adc_ctrl_pkg::SETTLE_LAST);
    assign bit_decide = (state == adc_ctrl_pkg::ST_SAR) && (slot_cnt == adc_ctrl_pkg::BIT_SLOT_LAST);
    assign conv_end = (state == adc_ctrl_pkg::ST_SAR) && (conv_cnt == adc_ctrl_pkg::CONV_LAST);
    assign trial = work | (8'h01 << bit_idx);
    // Start sample on the new address unless the host holds it; host mode also tracks while idle
    assign auto_take = (~host_s2 || ~hold_s2) && (state == adc_ctrl_pkg::ST_SETTLE)
        && (conv_cnt == 6'h0);
    assign host_track = host_s2 && ~hold_s2 && (state == adc_ctrl_pkg::ST_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            adc_ctrl_pkg::ST_IDLE: begin
                if (start_pulse) begin
                    next_state = adc_ctrl_pkg::ST_SETTLE;
                end
            end
            adc_ctrl_pkg::ST_SETTLE: begin
                if (settle_end) begin
                    next_state = adc_ctrl_pkg::ST_SAR;
                end
            end
            adc_ctrl_pkg::ST_SAR: begin
                if (conv_end) begin
                    next_state = adc_ctrl_pkg::ST_DONE;
                end
            end
            adc_ctrl_pkg::ST_DONE: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
            default: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= adc_ctrl_pkg::ST_IDLE;
            conv_cnt <= 6'h0;
            slot_cnt <= 2'h0;
        end else begin
            state <= next_state;
            if (state == adc_ctrl_pkg::ST_IDLE) begin
                conv_cnt <= 6'h0;
                slot_cnt <= 2'h0;
            end else begin
                conv_cnt <= conv_cnt + 6'h1;
                slot_cnt <= (state == adc_ctrl_pkg::ST_SAR) ? slot_cnt + 2'h1 : 2'h0;
            end
        end
    end

    // Address captured once the start event has crossed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_addr <= adc_ctrl_pkg::ADDR_RESET;
        end else if (start_pulse && (state == adc_ctrl_pkg::ST_IDLE)) begin
            conv_addr <= addr_hold;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sample <= 8'h00;
        end else if (auto_take || host_track) begin
            sample <= sel_level;
        end
    end

    // One bit decided per four-cycle slot, MSB first
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            work <= 8'h00;
            bit_idx <= adc_ctrl_pkg::MSB_INDEX;
            result <= adc_ctrl_pkg::RESULT_RESET;
        end else if (settle_end) begin
            work <= 8'h00;
            bit_idx <= adc_ctrl_pkg::MSB_INDEX;
        end else if (bit_decide) begin
            if (sample >= trial) begin
                work <= trial;
            end
            bit_idx <= bit_idx - 3'h1;
            if (conv_end) begin
                result <= (sample >= trial) ? trial : work;
            end
        end
    end

    // ********************************
    // Serial result output
    // ********************************
    logic [3:0] out_cnt;
    logic [2:0] out_idx;
    logic [7:0] out_word;

    // Word on the pin frozen for the whole frame
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_word <= adc_ctrl_pkg::RESULT_RESET;
        end else if (sel_s2) begin
            out_word <= result;
        end
    end

    assign out_cnt = {gray_s2[3], gray_s2[3] ^ gray_s2[2], gray_s2[3] ^ gray_s2[2] ^ gray_s2[1],
        gray_s2[3] ^ gray_s2[2] ^ gray_s2[1] ^ gray_s2[0]};
    // MSB until the filter has passed, then one bit per falling edge
    assign out_idx = !frame_live ? adc_ctrl_pkg::MSB_INDEX :
        (out_cnt >= adc_ctrl_pkg::OUT_EDGES) ? 3'h0 : 3'(adc_ctrl_pkg::MSB_INDEX - out_cnt[2:0]);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_dout <= out_word[out_idx];
            o_dout_oe <= ~sel_s2;
            o_busy <= (next_state != adc_ctrl_pkg::ST_IDLE);
        end
    end
endmodule

// ===== design/adc_ctrl_pkg.sv
// Constants and types shared by the serial converter control logic
package adc_ctrl_pkg;
    // ********************************
    // Widths and counts
    // ********************************
    localparam int RES_BITS = 8;
    localparam int ADDR_BITS = 4;
    localparam int NUM_EXT = 11;
    localparam int NUM_SRC = 12;
    localparam int AIN_BITS = NUM_EXT * RES_BITS;
    // ********************************
    // Timing in system clock cycles
    // ********************************
    localparam int CONV_CYCLES = 36;
    localparam int SETTLE_CYCLES = 4;
    localparam int BIT_CYCLES = 4;
    localparam int FILTER_CYCLES = 3;
    localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
    localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYCLES - 1);
    localparam logic [1:0] BIT_SLOT_LAST = 2'(BIT_CYCLES - 1);
    localparam logic [1:0] FILTER_LOAD = 2'(FILTER_CYCLES);
    // ********************************
    // Shift clock edge counts
    // ********************************
    localparam logic [3:0] START_EDGE = 4'h8;
    localparam logic [3:0] OUT_EDGES = 4'h7;
    localparam logic [2:0] ADDR_EDGES = 3'h4;
    // ********************************
    // Sources and reset values
    // ********************************
    localparam logic [3:0] SELFTEST_ADDR = 4'hB;
    localparam logic [7:0] SELFTEST_CODE = 8'h80;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [3:0] ADDR_RESET = 4'h0;
    localparam logic [2:0] MSB_INDEX = 3'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_SAR = 2'b11,
        ST_DONE = 2'b10
    } conv_state_type;
endpackage

// ===== bench/adc_ctrl_asserts.sv
// Port checker for the serial converter control block
`timescale 1ns/1ps
module adc_ctrl_asserts (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_io_clk,
    input wire logic i_sel_n,
    input wire logic i_addr_in,
    input wire logic [adc_ctrl_pkg::AIN_BITS-1:0] i_ain,
    input wire logic i_host_sample,
    input wire logic i_hold_req,
    input wire logic o_dout,
    input wire logic o_dout_oe,
    input wire logic o_busy
);
    localparam int BUSY_MIN = 36;
    localparam int BUSY_MAX = 39;
    logic [3:0] fall_cnt;
    logic [7:0] busy_cnt;
    logic io_s;
    logic io_d;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ****************
    // Helper counters
    // ****************
    // Shift clock falls counted in the system domain, cleared while deselected
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            io_s <= 1'b0;
            io_d <= 1'b0;
            fall_cnt <= 4'h0;
        end else begin
            io_s <= i_io_clk;
            io_d <= io_s;
            if (i_sel_n) begin
                fall_cnt <= 4'h0;
            end else if (io_d && !io_s && (fall_cnt != 4'h8)) begin
                fall_cnt <= fall_cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt <= 8'h00;
        else busy_cnt <= o_busy ? busy_cnt + 8'h01 : 8'h00;
    end
    // ****************
    // Assertions
    // ****************
    chk_oe_on_sel: assert property ($fell(i_sel_n) ##0 (!i_sel_n) [*5] |-> o_dout_oe)
        else $error("output not enabled after select fell");
    chk_oe_off_idle: assert property (i_sel_n [*4] |-> !o_dout_oe)
        else $error("output driven while deselected");
    chk_msb_hold: assert property ($rose(o_dout_oe) |=> $stable(o_dout) [*2])
        else $error("first bit not held during filter");
    chk_lsb_hold: assert property ((fall_cnt >= 4'h7) [*6] |-> $stable(o_dout))
        else $error("last bit not held");
    chk_busy_len: assert property ($fell(o_busy) |-> busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX)
        else $error("conversion length wrong");
    chk_busy_cause: assert property ($rose(o_busy) |-> fall_cnt == 4'h8)
        else $error("conversion started without eighth edge");
    chk_start_busy: assert property ($rose(fall_cnt == 4'h8) |-> ##[1:7] o_busy)
        else $error("eighth edge did not start conversion");
    chk_reset_idle: assert property ($rose(i_rst_n) |-> !o_busy && !o_dout_oe)
        else $error("outputs active after reset");
    cover property ($rose(o_busy));
    cover property ($rose(o_dout_oe));
    cover property (fall_cnt == 4'h5 && i_sel_n);
endmodule
bind serial_adc_control_interface adc_ctrl_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_io_clk(i_io_clk), .i_sel_n(i_sel_n), .i_addr_in(i_addr_in), .i_ain(i_ain),
    .i_host_sample(i_host_sample), .i_hold_req(i_hold_req), .o_dout(o_dout),
    .o_dout_oe(o_dout_oe), .o_busy(o_busy));

// ===== bench/adc_host_model.sv
// Host side model driving select, shift clock and address
`timescale 1ns/1ps
module adc_host_model (
    input wire logic i_dout,
    input wire logic i_dout_oe,
    output logic o_sel_n,
    output logic o_io_clk,
    output logic o_addr_in
);
    wire logic dout_line = i_dout_oe ? i_dout : 1'bz;
    initial begin
        o_sel_n = 1'b1;
        o_io_clk = 1'b0;
        o_addr_in = 1'b0;
    end
    task automatic frame(input logic [3:0] a, input int edges, input int tail, output logic [7:0] d);
        logic [7:0] bits;
        bits = {a, ~a};
        d = 8'h00;
        #13;
        o_sel_n = 1'b0;
        #250;
        d[7] = dout_line;
        for (int k = 1; k <= edges; k++) begin
            o_addr_in = bits[8-k];
            #32 o_io_clk = 1'b1;
            #32 o_io_clk = 1'b0;
            o_addr_in = ~o_addr_in;
            #200;
            if (k <= 7) d[7-k] = dout_line;
        end
        #(tail);
        o_sel_n = 1'b1;
        #1200;
    endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module tb;
    logic i_clk;
    logic i_rst_n;
    logic [adc_ctrl_pkg::AIN_BITS-1:0] i_ain;
    logic i_host_sample;
    logic i_hold_req;
    wire logic sel_n, io_clk, addr_in, dout, dout_oe, busy;
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] prev;
    serial_adc_control_interface u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_clk(io_clk),
        .i_sel_n(sel_n), .i_addr_in(addr_in), .i_ain(i_ain), .i_host_sample(i_host_sample),
        .i_hold_req(i_hold_req), .o_dout(dout), .o_dout_oe(dout_oe), .o_busy(busy));
    adc_host_model u_host (.i_dout(dout), .i_dout_oe(dout_oe), .o_sel_n(sel_n),
        .o_io_clk(io_clk), .o_addr_in(addr_in));
    function automatic logic [7:0] level(input logic [3:0] a);
        return (a < 4'hB) ? i_ain[a*8 +: 8] : adc_ctrl_pkg::SELFTEST_CODE;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic [3:0] a, input int edges, input int tail, input logic [7:0] exp);
        logic [7:0] d;
        u_host.frame(a, edges, tail, d);
        check("result", d, exp);
        check("busy", {7'h00, busy}, 8'h00);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        check("oe", {7'h00, dout_oe}, 8'h00);
        check("busy", {7'h00, busy}, 8'h00);
        xfer(4'h0, 8, 1000, adc_ctrl_pkg::RESULT_RESET);
        prev = level(4'h0);
    endtask
    task automatic t_channels;
        for (int a = 1; a < 16; a++) begin
            xfer(4'(a), 8, (a % 2) * 1000, prev);
            prev = level(4'(a));
        end
    endtask
    task automatic t_short;
        xfer(4'h5, 5, 1000, {prev[7:2], 2'b00});
        xfer(4'h2, 8, 1000, prev);
        prev = level(4'h2);
    endtask
    task automatic t_host;
        logic [7:0] held;
        xfer(4'h3, 8, 1000, prev);
        held = level(4'h3);
        @(negedge i_clk);
        i_host_sample = 1'b1;
        repeat (10) @(negedge i_clk);
        i_hold_req = 1'b1;
        repeat (10) @(negedge i_clk);
        i_ain[31:24] = ~held;
        xfer(4'h3, 8, 1000, held);
        @(negedge i_clk);
        i_hold_req = 1'b0;
        repeat (10) @(negedge i_clk);
        xfer(4'h3, 8, 1000, held);
        xfer(4'h3, 8, 1000, ~held);
        @(negedge i_clk);
        i_host_sample = 1'b0;
    endtask
    // ****************
    // Clock and run
    // ****************
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #500us;
        miscompares++;
        test_done;
    end
    initial begin
        i_rst_n = 1'b0;
        i_host_sample = 1'b0;
        i_hold_req = 1'b0;
        for (int n = 0; n < adc_ctrl_pkg::NUM_EXT; n++) i_ain[n*8 +: 8] = 8'(8'h1D * n + 8'h05);
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        t_reset;
        t_channels;
        t_short;
        t_host;
        test_done;
    end
endmodule
